//--- hdl/aca_adc_ctrl.sv
// converter control block with apb register access
//
// How it works
// RULE_01: eight bits by approximation, clock divided twelve
// RULE_02: start write begins conversion, clears done flag
// RULE_03: completion sets done, result becomes valid
// RULE_04: one conversion per start, then idle
// RULE_05: start during conversion abandons and restarts
// RULE_06: start bit reads back as zero
// RULE_07: done with enable raises vector four request
// RULE_08: control layout irq, done, start, power
// RULE_09: power bit off puts converter idle
// RULE_10: software powers converter before starting
// RULE_11: wait state does not stop conversion
// RULE_12: reset aborts, control loads 40h
// RULE_13: result at 0D0h, control at 0D1h
// RULE_14: software selects only one analog line
// RULE_15: channel comes from port configuration only
// RULE_16: software reads result only when done
// RULE_17: conversion time scales with clock period
// RULE_18: software may wait with timer stopped
// RULE_19: bits msb first, result updated at end
// RULE_20: reads have no side effect
// RULE_21: prescaler and step counter restart on start
`timescale 1ns/100ps
`default_nettype none

module aca_adc_ctrl (
  input  wire logic        clock,                  // 40 mhz system clock
  input  wire logic        rst_n,                  // synchronous reset, low
  input  wire logic        psel,                   // apb select
  input  wire logic        penable,                // apb access phase
  input  wire logic        pwrite,                 // apb direction
  input  wire logic [11:0] paddr,                  // apb byte address
  input  wire logic [31:0] pwdata,                 // apb write data
  output logic      [31:0] prdata,                 // apb read data
  output logic             pready,                 // apb transfer done
  output logic             pslverr,                // apb unmapped address
  input  wire logic        comp_in,                // comparator decision
  output logic      [7:0]  dac_code,               // trial code to the dac
  output logic             adc_power,              // converter supply on
  output logic             irq                     // end of conversion request
);

  // control and result state
  logic       irq_en_reg;                          // interrupt enable
  logic       done_reg;                            // conversion complete
  logic       power_reg;                           // converter powered
  logic [7:0] result_reg;                          // last finished code
  logic       irq_reg;                             // registered request
  logic [31:0] prdata_reg;                         // registered read data
  logic        pready_reg;                         // registered ready
  logic        pslverr_reg;                        // registered error

  // bus decode
  logic access;                                    // access phase, ready seen
  logic hit_ctrl;                                  // control word addressed
  logic hit_result;                                // result word addressed
  logic ctrl_wr;                                   // control write commits
  logic start_wr;                                  // start accepted this edge
  logic irq_en_next;                               // enable after this edge
  logic done_next;                                 // done after this edge

  // engine connections
  logic       tick;                                // converter clock step
  logic       sar_busy;                            // conversion running
  logic       sar_done;                            // conversion finished
  logic [7:0] sar_code;                            // finished code
  aca_pkg::aca_ctrl_t ctrl_view;                   // control read image

  assign hit_ctrl   = (paddr == aca_pkg::CONTROL_ADDR); // RULE_13
  assign hit_result = (paddr == aca_pkg::RESULT_ADDR);  // RULE_13
  assign access     = psel && penable && pready_reg;
  assign ctrl_wr    = access && pwrite && hit_ctrl;
  // start needs the power bit set in this same write; power set earlier is not enough
  assign start_wr   = ctrl_wr && pwdata[aca_pkg::START_BIT]
                      && pwdata[aca_pkg::POWER_BIT]; // RULE_02

  // engine sees the power bit as it stands after this edge, so a start
  // written together with the power bit is not lost to the old state
  logic power_next;                                // power bit after this edge
  assign power_next = ctrl_wr ? pwdata[aca_pkg::POWER_BIT] : power_reg; // RULE_09

  // control read image; start always reads zero
  always_comb begin
    ctrl_view        = '0;
    ctrl_view.irq_en = irq_en_reg; // RULE_08
    ctrl_view.done   = done_reg;
    ctrl_view.start  = 1'b0; // RULE_06
    ctrl_view.power  = power_reg;
  end

  // prescaler: one step every twelve system cycles
  aca_prescaler u_prescaler (
    .clock   (clock),
    .rst_n   (rst_n),
    .restart (start_wr),
    .run     (power_next),
    .tick    (tick)
  );

  // approximation engine; the comparator sees whichever line the port
  // configuration routes to it, so no channel select lives here
  aca_sar u_sar (
    .clock   (clock),
    .rst_n   (rst_n),
    .restart (start_wr), // RULE_05
    .run     (power_next),
    .tick    (tick),
    .comp_in (comp_in), // RULE_15
    .trial   (dac_code),
    .busy    (sar_busy),
    .done    (sar_done),
    .code    (sar_code)
  );

  // apb handshake: one wait state so read data comes from a flop
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (psel && penable && !pready_reg) begin
      pready_reg  <= 1'b1;
      pslverr_reg <= !(hit_ctrl || hit_result);
      // read data sampled here; reading changes no state
      if (!pwrite && hit_ctrl) begin
        prdata_reg <= {24'h000000, ctrl_view}; // RULE_20
      end else if (!pwrite && hit_result) begin
        prdata_reg <= {24'h000000, result_reg};
      end else begin
        prdata_reg <= 32'h0000_0000;
      end
    end else begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end
  end

  assign pready  = pready_reg;
  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg;

  // enable and power bits, written by software
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_en_reg <= aca_pkg::CONTROL_RESET[aca_pkg::IRQ_EN_BIT]; // RULE_12
      power_reg  <= aca_pkg::CONTROL_RESET[aca_pkg::POWER_BIT];
    end else if (ctrl_wr) begin
      irq_en_reg <= pwdata[aca_pkg::IRQ_EN_BIT]; // RULE_08
      // only this bit powers down; a wait state does not touch it
      power_reg  <= pwdata[aca_pkg::POWER_BIT]; // RULE_11
    end
  end

  // done flag: a start abandons any finishing conversion, so it clears
  always_comb begin
    irq_en_next = ctrl_wr ? pwdata[aca_pkg::IRQ_EN_BIT] : irq_en_reg;
    if (start_wr) begin
      done_next = 1'b0; // RULE_02
    end else if (sar_done) begin
      done_next = 1'b1; // RULE_03
    end else begin
      done_next = done_reg; // RULE_20
    end
  end

  // done flag and request register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      done_reg <= aca_pkg::CONTROL_RESET[aca_pkg::DONE_BIT]; // RULE_12
      irq_reg  <= 1'b0;
    end else begin
      done_reg <= done_next;
      irq_reg  <= done_next && irq_en_next; // RULE_07
    end
  end

  // result register loads only on completion
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      result_reg <= 8'h00;
    end else if (sar_done && !start_wr) begin
      result_reg <= sar_code; // RULE_19
    end
  end

  // converter supply output
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      adc_power <= aca_pkg::CONTROL_RESET[aca_pkg::POWER_BIT];
    end else begin
      adc_power <= power_next; // RULE_09
    end
  end

  assign irq = irq_reg;

  // checks on the control logic, clocked by the system clock
  localparam int CONV_CYCLES_I = int'(aca_pkg::CONV_CYCLES); // start to completion

  logic [9:0] since_start;                         // cycles since last start

  // helper: cycles elapsed since the accepted start
  always_ff @(posedge clock) begin
    if (!rst_n || start_wr) begin
      since_start <= 10'h001;
    end else if (since_start != 10'h3FF) begin
      since_start <= since_start + 10'h001;
    end
  end

  // all checks share one clock and are off while reset is applied
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // a start loads the first trial code and raises busy one cycle later
  sequence s_started;
    start_wr ##1 (sar_busy && dac_code == 8'h80);
  endsequence

  // no converter step in the eight cycles that follow one
  sequence s_tick_quiet;
    !tick [*8];
  endsequence

  // a start clears the done flag at its commit edge
  a_start_clears_done: assert property (start_wr |=> !done_reg) // RULE_02
    else $error("done not cleared by start");

  // finishing sets done unless a start abandons it
  a_done_on_finish: assert property (sar_done && !start_wr |=> done_reg) // RULE_03
    else $error("done not set at finish");

  // no conversion begins without a start
  a_stays_idle: assert property (!sar_busy && !start_wr |=> !sar_busy) // RULE_04
    else $error("conversion began without start");

  // a start in mid conversion begins afresh from the top bit
  a_restart_fresh: assert property (start_wr |-> s_started) // RULE_05
    else $error("start did not begin fresh conversion");

  // control reads never show the start bit; result reads may
  a_start_reads_zero: assert property (pready && hit_ctrl && !pwrite // RULE_06
    |-> !prdata[aca_pkg::START_BIT])
    else $error("start bit read as one");

  // the request is done gated by the enable
  a_irq_follows_done: assert property (irq == (done_reg && irq_en_reg)) // RULE_07
    else $error("request disagrees with done and enable");

  // a powered down converter never runs
  a_power_off_idle: assert property (!power_reg |-> !sar_busy) // RULE_09
    else $error("converter busy while powered down");

  // the supply output tracks the power bit
  a_supply_follows: assert property (adc_power == power_reg) // RULE_09
    else $error("supply output disagrees with power bit");

  // reset leaves done set, enable, power and request clear, engine idle
  a_reset_state: assert property ($rose(rst_n) |-> done_reg && !irq_en_reg // RULE_12
    && !power_reg && !sar_busy && !irq)
    else $error("wrong state after reset");

  // an unmapped word answers with an error
  a_unmapped_error: assert property (pready && !(hit_ctrl || hit_result) // RULE_13
    |-> pslverr)
    else $error("unmapped word answered without error");

  // ready stands for one cycle per transfer
  a_ready_pulse: assert property (pready |=> !pready) // RULE_13
    else $error("ready stood longer than one cycle");

  // completion comes a fixed number of cycles after the start
  a_conv_length: assert property (sar_done |-> since_start == CONV_CYCLES_I) // RULE_17
    else $error("conversion length wrong");

  // converter steps are at least nine system cycles apart
  a_tick_gap: assert property (tick |=> s_tick_quiet) // RULE_01
    else $error("converter steps too close together");

  // the first step after a start comes one full period later
  a_first_tick: assert property (tick && sar_busy && since_start <= 10'h00C // RULE_21
    |-> since_start == 10'h00C)
    else $error("prescaler not restarted by start");

  // the top bit is decided first, then the next trial bit goes up
  a_msb_first: assert property (sar_busy && since_start == 10'h03D // RULE_19
    |-> dac_code[6] && dac_code[5:0] == 6'h00)
    else $error("first decision not on the top bit");

  // the result word changes only at completion
  a_result_stable: assert property (!sar_done |=> $stable(result_reg)) // RULE_19
    else $error("result changed outside completion");

  // completion loads the finished code
  a_result_load: assert property (sar_done && !start_wr // RULE_19
    |=> result_reg == $past(sar_code))
    else $error("finished code not loaded");

  // reads leave the done flag alone
  a_read_no_effect: assert property (access && !pwrite && !sar_done // RULE_20
    |=> $stable(done_reg))
    else $error("read changed done flag");

  // done stands until the next start
  a_done_holds: assert property (done_reg && !start_wr |=> done_reg) // RULE_20
    else $error("done flag dropped without start");

endmodule

`default_nettype wire

//--- hdl/aca_pkg.sv
// constants and types shared by the converter control block
package aca_pkg;

  // bus geometry
  localparam int unsigned ADDR_W = 12;             // apb byte address width
  localparam int unsigned DATA_W = 32;             // apb data width
  localparam int unsigned CODE_W = 8;              // converter resolution

  // register indices as printed; byte address is four times the index
  localparam logic [ADDR_W-1:0] RESULT_IDX  = 12'h0D0;
  localparam logic [ADDR_W-1:0] CONTROL_IDX = 12'h0D1;
  localparam logic [ADDR_W-1:0] RESULT_ADDR  = 12'h340; // RESULT_IDX * 4
  localparam logic [ADDR_W-1:0] CONTROL_ADDR = 12'h344; // CONTROL_IDX * 4

  // control register field positions
  localparam int unsigned IRQ_EN_BIT = 7;          // interrupt enable
  localparam int unsigned DONE_BIT   = 6;          // conversion complete
  localparam int unsigned START_BIT  = 5;          // write-only start
  localparam int unsigned POWER_BIT  = 4;          // converter powered

  // control register reset value
  localparam logic [CODE_W-1:0] CONTROL_RESET = 8'h40;

  // timing: converter clock is the system clock divided by twelve
  localparam int unsigned PRESCALE      = 12;
  localparam logic [3:0]  PRESCALE_LAST = 4'hB;    // PRESCALE - 1
  // nominal conversion time at the reference oscillator rate
  localparam int unsigned CONV_TIME_NS  = 70000;
  localparam int unsigned REF_OSC_KHZ   = 8000;
  // converter clock ticks per conversion, rounded down
  localparam int unsigned CONV_TICKS =
    (CONV_TIME_NS * REF_OSC_KHZ) / (1000000 * PRESCALE);
  // converter clock ticks spent on each result bit
  localparam int unsigned BIT_TICKS  = CONV_TICKS / CODE_W;
  localparam logic [2:0]  BIT_LAST   = 3'(BIT_TICKS - 1);
  // system clock cycles from start write to completion pulse
  localparam int unsigned CONV_CYCLES = CODE_W * BIT_TICKS * PRESCALE;

  // control register image
  typedef struct packed {
    logic       irq_en;                            // interrupt enable
    logic       done;                              // conversion complete
    logic       start;                             // reads as zero
    logic       power;                             // converter powered
    logic [3:0] unused;                            // read as zero
  } aca_ctrl_t;

endpackage

//--- hdl/aca_prescaler.sv
// divide-by-twelve converter clock enable generator
`timescale 1ns/100ps
`default_nettype none

module aca_prescaler (
  input  wire logic clock,                         // system clock
  input  wire logic rst_n,                         // synchronous reset, low
  input  wire logic restart,                       // start or restart pulse
  input  wire logic run,                           // converter powered
  output logic      tick                           // one converter clock step
);

  logic [3:0] count_reg;                           // position within period

  // count twelve system cycles per step, restart from zero on command
  always_ff @(posedge clock) begin
    if (!rst_n || restart || !run) begin
      count_reg <= 4'h0; // RULE_21
    end else if (count_reg == aca_pkg::PRESCALE_LAST) begin
      count_reg <= 4'h0; // RULE_01
    end else begin
      count_reg <= count_reg + 4'h1;
    end
  end

  // step strobe on the last cycle of each period
  assign tick = run && !restart && (count_reg == aca_pkg::PRESCALE_LAST);

endmodule

`default_nettype wire

//--- hdl/aca_sar.sv
// successive approximation step engine
`timescale 1ns/100ps
`default_nettype none

module aca_sar (
  input  wire logic       clock,                   // system clock
  input  wire logic       rst_n,                   // synchronous reset, low
  input  wire logic       restart,                 // begin a fresh conversion
  input  wire logic       run,                     // converter powered
  input  wire logic       tick,                    // converter clock step
  input  wire logic       comp_in,                 // high: input at or above dac
  output logic [7:0]      trial,                   // code driven to the dac
  output logic            busy,                    // conversion in progress
  output logic            done,                    // completion pulse
  output logic [7:0]      code                     // final code, valid with done
);

  logic [2:0] bit_reg;                             // bit under decision
  logic [2:0] sub_reg;                             // ticks spent on this bit
  logic       decide;                              // decision point this cycle
  logic [7:0] decided;                             // trial with current bit settled

  assign decide = busy && tick && (sub_reg == aca_pkg::BIT_LAST);

  // keep the current bit only if the comparator says input is not below
  always_comb begin
    decided          = trial;
    decided[bit_reg] = trial[bit_reg] & comp_in;
  end

  assign done = decide && (bit_reg == 3'h0);
  assign code = decided;

  // trial code, bit pointer and busy flag, msb first
  always_ff @(posedge clock) begin
    if (!rst_n || !run) begin
      busy    <= 1'b0; // RULE_09
      bit_reg <= 3'h7;
      trial   <= 8'h00;
    end else if (restart) begin
      busy    <= 1'b1; // RULE_21
      bit_reg <= 3'h7;
      trial   <= 8'h80;
    end else if (decide) begin
      if (bit_reg == 3'h0) begin
        busy  <= 1'b0; // RULE_04
        trial <= decided;
      end else begin
        trial              <= decided;
        trial[bit_reg - 3'h1] <= 1'b1; // RULE_19
        bit_reg            <= bit_reg - 3'h1;
      end
    end
  end

  // tick counter inside one bit period
  always_ff @(posedge clock) begin
    if (!rst_n || !run || restart) begin
      sub_reg <= 3'h0; // RULE_21
    end else if (busy && tick) begin
      sub_reg <= (sub_reg == aca_pkg::BIT_LAST) ? 3'h0 : sub_reg + 3'h1;
    end
  end

endmodule

`default_nettype wire

//--- sim/aca_analog_src.sv
// model of the single selected analog input line and its comparator
`timescale 1ns/100ps
`default_nettype none

module aca_analog_src (
  input  wire logic [7:0] dac_code,   // trial code from the converter
  input  wire logic       adc_power,  // comparator supply
  input  wire logic [7:0] level,      // analog level as a code
  output logic            comp_in     // high when input at or above trial
);
  // one line only feeds the converter, there is no channel field
  // an unpowered comparator gives no valid decision, so it reads low
  assign comp_in = adc_power ? (level >= dac_code) : 1'b0;
endmodule

`default_nettype wire

//--- sim/aca_adc_ctrl_test.sv
// self-checking bench for the converter control block
`timescale 1ns/100ps
`default_nettype none

module aca_adc_ctrl_test;
  logic        clock;                 // system clock
  logic        rst_n;                 // reset, low
  logic        psel, penable, pwrite; // apb request
  logic [11:0] paddr;                 // apb address
  logic [31:0] pwdata, prdata;        // apb data
  logic        pready, pslverr;       // apb answer
  logic        comp_in, adc_power;    // comparator side
  logic        irq;                   // conversion request
  logic [7:0]  dac_code, level;       // trial code, analog level
  logic [31:0] rdv;                   // read data of last transfer
  logic        err;                   // error of last transfer
  int          num_errors, num_checks; // counters
  int          n;                     // cycles waited
  localparam logic [11:0] CTL = aca_pkg::CONTROL_ADDR; // control address
  localparam logic [11:0] RES = aca_pkg::RESULT_ADDR;  // result address

  aca_adc_ctrl dut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .comp_in(comp_in), .dac_code(dac_code), .adc_power(adc_power),
    .irq(irq));
  aca_analog_src src (.dac_code(dac_code), .adc_power(adc_power), .level(level),
    .comp_in(comp_in));

  // free running 40 mhz clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // verdict and end of run
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // compare one value with its expectation
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int k;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      num_errors++;
      final_report;
    end
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // register write
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // register read with expected word
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdv, exp);
  endtask

  // wait for the conversion request with a bound
  task automatic wait_irq(output int c);
    c = 0;
    while (irq !== 1'b1 && c < 1000) begin
      @(posedge clock);
      c++;
    end
    if (c >= 1000) begin
      num_errors++;
      final_report;
    end
  endtask

  // main sequence
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    level = 8'h00;
    num_errors = 0;
    num_checks = 0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    chk({31'h0, irq}, 32'h0);
    rd(CTL, 32'h40);
    rd(RES, 32'h00);
    apb(1'b0, 12'h348, 32'h0);
    chk({31'h0, err}, 32'h1);
    wr(RES, 32'hFF);
    rd(RES, 32'h00);
    // enable with done still set from reset raises the request
    wr(CTL, 32'h80);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h1);
    wr(CTL, 32'h00);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h0);
    // start while unpowered is ignored
    wr(CTL, 32'hA0);
    rd(CTL, 32'hC0);
    // power first, then start
    wr(CTL, 32'h90);
    @(posedge clock);
    chk({31'h0, adc_power}, 32'h1);
    level <= 8'hA5;
    wr(CTL, 32'hB0);
    repeat (2) @(posedge clock);
    chk({24'h0, dac_code}, 32'h80);
    rd(CTL, 32'h90);
    wait_irq(n);
    chk(32'(n >= 470 && n <= 490), 32'h1);
    rd(RES, 32'hA5);
    rd(CTL, 32'hD0);
    repeat (600) @(posedge clock);
    rd(CTL, 32'hD0);
    rd(RES, 32'hA5);
    // restart mid conversion with a new level
    level <= 8'h3C;
    wr(CTL, 32'hB0);
    repeat (200) @(posedge clock);
    level <= 8'hC3;
    wr(CTL, 32'hB0);
    wait_irq(n);
    chk(32'(n >= 470 && n <= 490), 32'h1);
    rd(RES, 32'hC3);
    // power off during a conversion aborts it
    level <= 8'h11;
    wr(CTL, 32'hB0);
    repeat (100) @(posedge clock);
    wr(CTL, 32'h80);
    repeat (600) @(posedge clock);
    rd(CTL, 32'h80);
    rd(RES, 32'hC3);
    chk({31'h0, irq}, 32'h0);
    chk({31'h0, adc_power}, 32'h0);
    // reset during a conversion
    wr(CTL, 32'h90);
    wr(CTL, 32'hB0);
    repeat (50) @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    chk({24'h0, dac_code}, 32'h00);
    rd(CTL, 32'h40);
    final_report;
  end
endmodule

`default_nettype wire
